// File: design/axmcs_fe_if.sv
`timescale 1ns/1ps
`default_nettype none
interface axmcs_fe_if;
    logic [31:0] target;
    logic [31:0] actual;
    logic [31:0] window;
    logic [31:0] timeout_ms;
    logic active;
    logic out_of_tol;
    logic fe_event;
    modport sup (
        input target, actual, window, timeout_ms, active,
        output out_of_tol, fe_event
    );
    modport ctl (
        output target, actual, window, timeout_ms, active,
        input out_of_tol, fe_event
    );
endinterface
`default_nettype wire

// File: design/axmcs_fe_sup.sv
`timescale 1ns/1ps
`default_nettype none
module axmcs_fe_sup import axmcs_pkg::*; #(
    parameter int CYC_MS = CYC_PER_MS
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // supervision signals
    axmcs_fe_if.sup fe
);
    logic [31:0] div_ff; // millisecond divider
    logic [31:0] tmo_cnt_ff; // elapsed ms out of tolerance
    logic [31:0] dev; // absolute deviation
    logic ms_tick;
    logic hit;

    // deviation against the tolerance window
    assign dev = ($signed(fe.actual) > $signed(fe.target)) ?
                 fe.actual - fe.target : fe.target - fe.actual;
    assign fe.out_of_tol = fe.active && (dev > fe.window); // RL13
    assign ms_tick = (div_ff == 32'(CYC_MS - 1));
    // fires only after the timeout has fully elapsed; zero disables
    assign hit = fe.out_of_tol && ms_tick && (fe.timeout_ms != 32'h0000_0000) // RL12
                 && (tmo_cnt_ff >= fe.timeout_ms); // RL14
    assign fe.fe_event = hit; // RL7

    // millisecond enable pulse
    always_ff @(posedge aclk) begin
        if (!aresetn || ms_tick) begin
            div_ff <= 32'h0000_0000;
        end else begin
            div_ff <= div_ff + 32'h0000_0001;
        end
    end

    // time spent out of tolerance, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn || !fe.out_of_tol) begin
            tmo_cnt_ff <= 32'h0000_0000;
        end else if (ms_tick && tmo_cnt_ff != 32'hFFFF_FFFF) begin
            tmo_cnt_ff <= tmo_cnt_ff + 32'h0000_0001;
        end
    end

    a_fe_zero_off: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
        fe.timeout_ms == 32'h0000_0000 |-> !fe.fe_event)
        else $error("following error raised with timeout zero");
    a_fe_in_window: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
        fe.fe_event |-> dev > fe.window && fe.active)
        else $error("following error inside tolerance window");
    a_fe_persist: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
        fe.fe_event |-> $past(fe.out_of_tol) && tmo_cnt_ff >= fe.timeout_ms)
        else $error("following error before timeout elapsed");
endmodule
`default_nettype wire

// File: design/axmcs_pkg.sv
package axmcs_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_SPEED = 8'h08;
    localparam logic [7:0] OFS_TARGET = 8'h0C;
    localparam logic [7:0] OFS_FE_WIN = 8'h10;
    localparam logic [7:0] OFS_FE_TMO = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_FCODE = 8'h1C;
    localparam logic [7:0] OFS_ACTUAL = 8'h20;
    // control word bits
    localparam int CTL_SWITCH_ON = 0;
    localparam int CTL_ERR_ACK = 1;
    localparam int CTL_BRAKE_OPEN = 2;
    localparam int CTL_BRAKE_CLOSE = 3;
    localparam int CTL_W = 4;
    // status word bits
    localparam int STS_TOGGLE = 0;
    localparam int STS_REFUSED = 1;
    localparam int STS_COMPLETE = 2;
    localparam int STS_ABORT = 3;
    localparam int STS_FAULT = 4;
    localparam int STS_BRAKE = 5;
    localparam int STS_BUSY = 6;
    localparam int STS_STATE = 8;
    // command words
    localparam logic [15:0] CMD_NONE = 16'h0000;
    localparam logic [15:0] CMD_ABS_POS = 16'h0104;
    // fault codes
    localparam logic [15:0] FC_NONE = 16'h0000;
    localparam logic [15:0] FC_VOLT_LO = 16'h0101;
    localparam logic [15:0] FC_VOLT_HI = 16'h0104;
    localparam logic [15:0] FC_TEMP_LO = 16'h0301;
    localparam logic [15:0] FC_TEMP_HI = 16'h0304;
    localparam logic [15:0] FC_BAD_CMD = 16'h0801;
    localparam logic [15:0] FC_EN_IN_FAULT = 16'h0803;
    localparam logic [15:0] FC_FOLLOW = 16'h0A01;
    // reset values
    localparam logic [31:0] FE_TMO_MS_RST = 32'h0000_01F4;
    localparam logic [31:0] FE_WINDOW_RST = 32'h0000_03E8;
    localparam logic [15:0] SLOW_SPEED_RST = 16'h0001;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_IN_NS = 1000000;
    localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // supervisor states, one-hot
    typedef enum logic [4:0] {
        ST_READY = 5'b00001,
        ST_ENABLED = 5'b00010,
        ST_INTERLOCK_HOLD = 5'b00100,
        ST_FAULT = 5'b01000,
        ST_ACK = 5'b10000
    } axmcs_state_t;

    // true for supply or temperature monitor codes
    function automatic logic is_hw_code(input logic [15:0] c);
        is_hw_code = (c >= FC_VOLT_LO && c <= FC_VOLT_HI) ||
                     (c >= FC_TEMP_LO && c <= FC_TEMP_HI);
    endfunction
endpackage

// File: design/axmcs_top.sv
// Behaviour
// RL1: host keeps switch-on low until ready
// RL2: zero speed selects built-in slow speed
// RL3: command 0x0104 starts absolute positioning
// RL4: toggle on each order, flag refused ones
// RL5: set complete on arrival, abort on failure
// RL6: new target under 0x0104 is new order
// RL7: blocked axis triggers following-error supervision
// RL8: brake request only in ready, fault, ack
// RL9: status bit shows brake released
// RL10: defaults 500 ms timeout, 1000 window
// RL11: following error locks, aborts, code 0x0A01
// RL12: zero timeout disables supervision
// RL13: deviation compared against tolerance window
// RL14: error only after timeout fully elapses
// RL15: any error halts drive, refuses motion
// RL16: fault code held until acknowledged
// RL17: fault codes none, supply, temperature ranges
// RL18: clear command and control to leave lock
// RL19: held acknowledge clears errors, returns ready
// RL20: toggle once per order, else steady
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module axmcs_top import axmcs_pkg::*; #(
    parameter int CYC_MS = CYC_PER_MS,
    parameter logic [15:0] SLOW_SPEED = SLOW_SPEED_RST
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // axis feedback and monitors
    input wire logic [31:0] actual_position,
    input wire logic [15:0] hw_fault_code,
    // drive outputs
    output logic drive_enable,
    output logic [31:0] setpoint_position,
    output logic [15:0] speed_setpoint,
    output logic brake_release
);
    // merge write data under byte strobes
    function automatic logic [31:0] strb_merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            strb_merge[i*8 +: 8] = s[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // bus slave state
    logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    // software registers
    logic [15:0] motion_command_word_ff; // command word
    logic [CTL_W-1:0] ctrl_ff; // control word
    logic [15:0] commanded_speed_ff; // zero means slow default
    logic [31:0] target_position_field_ff; // target position
    logic [31:0] fe_win_ff, fe_tmo_ff; // supervision settings
    // supervisor state
    axmcs_state_t state_ff, nxt_state;
    logic moving_ff, nxt_moving;
    logic order_accept_toggle_ff, nxt_toggle;
    logic order_refused_flag_ff, nxt_refused;
    logic motion_complete_flag_ff, nxt_complete;
    logic motion_abort_flag_ff, nxt_abort;
    logic brake_released_flag_ff, nxt_brake;
    logic [15:0] fault_code_ff, nxt_fcode;
    logic [31:0] setpoint_ff, nxt_setpoint;
    logic drive_en_ff;
    logic [15:0] speed_out_ff;

    // write decode
    logic wr_go, wr_hit, wr_cmd, wr_ctrl, wr_speed, wr_target, wr_win, wr_tmo;
    logic [31:0] cmd_wval, tgt_wval, ctrl_wval, spd_wval, win_wval, tmo_wval;
    logic [15:0] cmd_now;
    logic [31:0] tgt_now;
    logic order_req, order_is_abs, sw_on, ack_req, ctrl_zero, hw_err;
    logic brake_ok, at_target;
    logic [31:0] status_word, rd_val;
    logic rd_hit;
    axmcs_fe_if fe_bus();

    // handshakes: each address and data accepted independently
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready = !w_hold_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wr_cmd = wr_go && awaddr_ff == OFS_CMD;
    assign wr_ctrl = wr_go && awaddr_ff == OFS_CTRL;
    assign wr_speed = wr_go && awaddr_ff == OFS_SPEED;
    assign wr_target = wr_go && awaddr_ff == OFS_TARGET;
    assign wr_win = wr_go && awaddr_ff == OFS_FE_WIN;
    assign wr_tmo = wr_go && awaddr_ff == OFS_FE_TMO;
    assign wr_hit = wr_cmd || wr_ctrl || wr_speed || wr_target || wr_win || wr_tmo;
    assign cmd_wval = strb_merge({16'h0000, motion_command_word_ff}, wdata_ff, wstrb_ff);
    assign ctrl_wval = strb_merge({28'h000_0000, ctrl_ff}, wdata_ff, wstrb_ff);
    assign spd_wval = strb_merge({16'h0000, commanded_speed_ff}, wdata_ff, wstrb_ff);
    assign tgt_wval = strb_merge(target_position_field_ff, wdata_ff, wstrb_ff);
    assign win_wval = strb_merge(fe_win_ff, wdata_ff, wstrb_ff);
    assign tmo_wval = strb_merge(fe_tmo_ff, wdata_ff, wstrb_ff);
    assign cmd_now = wr_cmd ? cmd_wval[15:0] : motion_command_word_ff;
    assign tgt_now = wr_target ? tgt_wval : target_position_field_ff;

    // order detection: nonzero command write, or new target under 0x0104
    assign order_req = (wr_cmd && cmd_now != CMD_NONE) ||
                       (wr_target && motion_command_word_ff == CMD_ABS_POS); // RL6
    assign order_is_abs = (cmd_now == CMD_ABS_POS); // RL3
    assign sw_on = ctrl_ff[CTL_SWITCH_ON];
    assign ack_req = ctrl_ff[CTL_ERR_ACK];
    assign ctrl_zero = (ctrl_ff == '0);
    assign hw_err = is_hw_code(hw_fault_code); // RL17
    assign brake_ok = state_ff inside {ST_READY, ST_FAULT, ST_ACK}; // RL8
    assign at_target = (actual_position == setpoint_ff);

    // following-error supervisor
    assign fe_bus.target = setpoint_ff;
    assign fe_bus.actual = actual_position;
    assign fe_bus.window = fe_win_ff;
    assign fe_bus.timeout_ms = fe_tmo_ff;
    assign fe_bus.active = moving_ff && state_ff == ST_ENABLED; // RL7
    axmcs_fe_sup #(.CYC_MS(CYC_MS)) u_fe_sup (
        .aclk(aclk),
        .aresetn(aresetn),
        .fe(fe_bus.sup)
    );

    // status readback
    assign status_word = {19'h0_0000, state_ff, 1'b0, moving_ff,
        brake_released_flag_ff, fault_code_ff != FC_NONE, // RL9
        motion_abort_flag_ff, motion_complete_flag_ff,
        order_refused_flag_ff, order_accept_toggle_ff};
    assign rd_hit = s_axi_araddr <= OFS_ACTUAL && s_axi_araddr[1:0] == 2'b00;
    assign rd_val = (s_axi_araddr == OFS_CMD) ? {16'h0000, motion_command_word_ff} :
        (s_axi_araddr == OFS_CTRL) ? {28'h000_0000, ctrl_ff} :
        (s_axi_araddr == OFS_SPEED) ? {16'h0000, commanded_speed_ff} :
        (s_axi_araddr == OFS_TARGET) ? target_position_field_ff :
        (s_axi_araddr == OFS_FE_WIN) ? fe_win_ff :
        (s_axi_araddr == OFS_FE_TMO) ? fe_tmo_ff :
        (s_axi_araddr == OFS_STATUS) ? status_word :
        (s_axi_araddr == OFS_FCODE) ? {16'h0000, fault_code_ff} :
        actual_position;

    // write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                // commit: both halves held, answer next cycle
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_hit ? rd_val : 32'h0000_0000;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            motion_command_word_ff <= CMD_NONE;
            ctrl_ff <= '0;
            commanded_speed_ff <= 16'h0000;
            target_position_field_ff <= 32'h0000_0000;
            fe_win_ff <= FE_WINDOW_RST; // RL10
            fe_tmo_ff <= FE_TMO_MS_RST; // RL10
        end else begin
            motion_command_word_ff <= cmd_now;
            target_position_field_ff <= tgt_now;
            if (wr_ctrl) ctrl_ff <= ctrl_wval[CTL_W-1:0];
            if (wr_speed) commanded_speed_ff <= spd_wval[15:0];
            if (wr_win) fe_win_ff <= win_wval;
            if (wr_tmo) fe_tmo_ff <= tmo_wval;
        end
    end

    // supervisor next state
    always_comb begin
        nxt_state = state_ff;
        nxt_moving = moving_ff;
        nxt_toggle = order_accept_toggle_ff;
        nxt_refused = order_refused_flag_ff;
        nxt_complete = motion_complete_flag_ff;
        nxt_abort = motion_abort_flag_ff;
        nxt_fcode = fault_code_ff;
        nxt_setpoint = setpoint_ff;
        nxt_brake = brake_released_flag_ff;
        case (state_ff)
            ST_READY: begin
                if (hw_err) begin
                    nxt_state = ST_FAULT; // RL15
                    nxt_fcode = hw_fault_code;
                end else if (order_req || (sw_on && motion_command_word_ff != CMD_NONE)) begin
                    nxt_state = ST_FAULT; // RL1
                    nxt_fcode = FC_BAD_CMD;
                end else if (sw_on) begin
                    nxt_state = ST_ENABLED;
                    nxt_setpoint = actual_position;
                end
            end
            ST_ENABLED: begin
                if (hw_err || fe_bus.fe_event) begin
                    // halt and lock; supply or thermal code wins
                    nxt_state = ST_INTERLOCK_HOLD; // RL15
                    nxt_moving = 1'b0;
                    nxt_abort = moving_ff; // RL5
                    nxt_fcode = hw_err ? hw_fault_code : FC_FOLLOW; // RL11
                end else if (!sw_on) begin
                    nxt_state = ST_READY;
                    nxt_moving = 1'b0;
                end else if (order_req) begin
                    nxt_toggle = !order_accept_toggle_ff; // RL4 RL20
                    nxt_refused = !order_is_abs; // RL4
                    if (order_is_abs) begin
                        nxt_setpoint = tgt_now; // RL3 RL6
                        nxt_moving = 1'b1;
                        nxt_complete = 1'b0;
                        nxt_abort = 1'b0;
                    end
                end else if (moving_ff && at_target) begin
                    nxt_moving = 1'b0;
                    nxt_complete = 1'b1; // RL5
                end
            end
            ST_INTERLOCK_HOLD: begin
                if (motion_command_word_ff == CMD_NONE && ctrl_zero) begin
                    nxt_state = ST_FAULT; // RL18
                end
            end
            ST_FAULT: begin
                if (sw_on) begin
                    if (fault_code_ff == FC_NONE) nxt_fcode = FC_EN_IN_FAULT;
                end else if (ack_req) begin
                    nxt_state = ST_ACK; // RL19
                end
            end
            ST_ACK: begin
                if (!hw_err) begin
                    nxt_fcode = FC_NONE; // RL19
                    nxt_abort = 1'b0;
                    nxt_state = ST_READY;
                end else if (!ack_req) begin
                    nxt_state = ST_FAULT;
                end
            end
            default: begin
                nxt_state = ST_FAULT;
            end
        endcase
        // manual brake only while no motion can run
        if (brake_ok && ctrl_ff[CTL_BRAKE_OPEN]) begin
            nxt_brake = 1'b1; // RL8
        end else if (brake_ok && ctrl_ff[CTL_BRAKE_CLOSE]) begin
            nxt_brake = 1'b0; // RL8
        end
    end

    // supervisor registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_READY;
            moving_ff <= 1'b0;
            order_accept_toggle_ff <= 1'b0;
            order_refused_flag_ff <= 1'b0;
            motion_complete_flag_ff <= 1'b0;
            motion_abort_flag_ff <= 1'b0;
            fault_code_ff <= FC_NONE;
            setpoint_ff <= 32'h0000_0000;
            brake_released_flag_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            moving_ff <= nxt_moving;
            order_accept_toggle_ff <= nxt_toggle;
            order_refused_flag_ff <= nxt_refused;
            motion_complete_flag_ff <= nxt_complete;
            motion_abort_flag_ff <= nxt_abort;
            fault_code_ff <= nxt_fcode; // RL16
            setpoint_ff <= nxt_setpoint;
            brake_released_flag_ff <= nxt_brake; // RL9
        end
    end

    // drive outputs, registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_en_ff <= 1'b0;
            speed_out_ff <= 16'h0000;
        end else begin
            drive_en_ff <= nxt_state == ST_ENABLED; // RL15
            speed_out_ff <= (commanded_speed_ff == 16'h0000) ?
                SLOW_SPEED : commanded_speed_ff; // RL2
        end
    end
    assign drive_enable = drive_en_ff;
    assign speed_setpoint = speed_out_ff;
    assign setpoint_position = setpoint_ff;
    assign brake_release = brake_released_flag_ff;

    a_abs_accept: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
        state_ff == ST_ENABLED && sw_on && order_req && order_is_abs && !hw_err
        && !fe_bus.fe_event |=> order_accept_toggle_ff != $past(order_accept_toggle_ff)
        && moving_ff && !order_refused_flag_ff && setpoint_ff == $past(tgt_now))
        else $error("absolute order not accepted");
    a_toggle_steady: assert property (@(posedge aclk) disable iff (!aresetn) // RL20
        !order_req |=> $stable(order_accept_toggle_ff))
        else $error("toggle moved without an order");
    a_speed_slow: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
        aresetn && commanded_speed_ff == 16'h0000 |=> speed_setpoint == SLOW_SPEED)
        else $error("zero speed did not select slow default");
    a_follow_lock: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
        state_ff == ST_ENABLED && fe_bus.fe_event && !hw_err |=>
        state_ff == ST_INTERLOCK_HOLD && motion_abort_flag_ff
        && fault_code_ff == FC_FOLLOW && !drive_enable && !moving_ff)
        else $error("following error did not lock the axis");
    a_code_latch: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
        fault_code_ff != FC_NONE && state_ff != ST_ACK |=> $stable(fault_code_ff))
        else $error("fault code changed without acknowledge");
    a_brake_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
        state_ff inside {ST_ENABLED, ST_INTERLOCK_HOLD} |=> $stable(brake_release))
        else $error("brake moved in a forbidden state");
    a_done_flag: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
        state_ff == ST_ENABLED && moving_ff && at_target && sw_on && !order_req
        && !hw_err && !fe_bus.fe_event |=> motion_complete_flag_ff && !moving_ff)
        else $error("arrival did not set completion");
    a_lock_exit: assert property (@(posedge aclk) disable iff (!aresetn) // RL18
        state_ff == ST_INTERLOCK_HOLD && motion_command_word_ff == CMD_NONE
        && ctrl_zero |=> state_ff == ST_FAULT)
        else $error("interlock not left after clearing words");
    a_halt_error: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
        fault_code_ff != FC_NONE |-> !drive_enable && !moving_ff)
        else $error("drive active while a fault is latched");
endmodule
`default_nettype wire

// File: testbench/axmcs_axis_model.sv
`timescale 1ns/1ps
`default_nettype none
// axis stand-in: actual position creeps one unit a cycle toward setpoint while driven and not blocked
module axmcs_axis_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // drive side
    input wire logic drive_enable,
    input wire logic [31:0] setpoint_position,
    input wire logic blocked,
    // feedback
    output logic [31:0] actual_position
);
    // a blocked axis stands still even while driven
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            actual_position <= 32'h0000_0000;
        end else if (drive_enable && !blocked && actual_position != setpoint_position) begin
            actual_position <= ($signed(actual_position) < $signed(setpoint_position)) ?
                actual_position + 32'h0000_0001 : actual_position - 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// File: testbench/test_axis_motion_command_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module test_axis_motion_command_supervisor import axmcs_pkg::*; ;
    // bench side of every port
    // response readies stay high, so every answer is taken at the edge it is seen
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 1, blocked = 0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, actual_position, setpoint_position, s, s0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [15:0] hw_fault_code = '0, speed_setpoint;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic drive_enable, brake_release;
    int n_fail = 0, n_compared = 0;
    axmcs_top #(.CYC_MS(10)) dut (.*);
    axmcs_axis_model model (.*);
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    task final_report;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] g, e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    // axi write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        logic [2:0] t;
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
        for (i = 0; i < 99; i++) begin
            @(negedge aclk) t = {s_axi_bvalid, s_axi_awready, s_axi_wready};
            @(posedge aclk) if (t[1]) s_axi_awvalid <= 1'h0;
            if (t[0]) s_axi_wvalid <= 1'h0;
            if (t[2]) break;
        end
        if (i == 99) begin n_fail++; final_report; end
    endtask
    // axi read into s and rr
    task automatic rd(input logic [7:0] a);
        int i;
        logic [1:0] t;
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1;
        for (i = 0; i < 99; i++) begin
            @(negedge aclk) t = {s_axi_rvalid, s_axi_arready};
            s = s_axi_rdata; rr = s_axi_rresp;
            @(posedge aclk) if (t[0]) s_axi_arvalid <= 1'h0;
            if (t[1]) break;
        end
        if (i == 99) begin n_fail++; final_report; end
    endtask
    // poll status until masked bits match
    task automatic wt(input logic [31:0] m, v);
        int j;
        for (j = 0; j < 200; j++) begin
            rd(OFS_STATUS);
            if ((s & m) === v) break;
        end
        if (j == 200) begin n_fail++; final_report; end
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        rd(OFS_FE_WIN); chk("win", s, FE_WINDOW_RST);
        rd(OFS_FE_TMO); chk("tmo", s, FE_TMO_MS_RST);
        wt(32'h0000_1F00, 32'h0000_0100);
        wr(OFS_CTRL, 32'h0000_0001);
        wt(32'h0000_1F00, 32'h0000_0200);
        chk("slow", speed_setpoint, SLOW_SPEED_RST);
        wr(OFS_SPEED, 32'h0000_0014); wr(OFS_TARGET, 32'h0000_0032);
        rd(OFS_STATUS); s0 = s; wr(OFS_CMD, CMD_ABS_POS);
        rd(OFS_STATUS); chk("acc", s[1:0], {1'h0, ~s0[0]});
        wt(32'h0000_0004, 32'h0000_0004);
        chk("pos", setpoint_position, 32'h0000_0032);
        chk("spd", speed_setpoint, 32'h0000_0014);
        wr(OFS_CTRL, 32'h0000_0005); rd(OFS_STATUS); chk("bgate", s[5], 1'h0);
        s0 = s; wr(OFS_TARGET, 32'h0000_0050);
        wt(32'h0000_0004, 32'h0000_0004);
        chk("tgl", s[0], !s0[0]);
        chk("new", actual_position, 32'h0000_0050);
        wr(OFS_CMD, 32'h0000_0002);
        rd(OFS_STATUS); chk("ref", s[1:0], {1'h1, s0[0]});
        wr(OFS_FE_WIN, 32'h0000_000A); wr(OFS_FE_TMO, 32'h0000_0000);
        blocked <= 1'h1; wr(OFS_TARGET, 32'h0000_01F4); wr(OFS_CMD, CMD_ABS_POS);
        repeat (10) rd(OFS_STATUS);
        chk("off", s[12:6], 7'h09);
        wr(OFS_FE_TMO, 32'h0000_0001);
        wt(32'h0000_1F00, 32'h0000_0400);
        chk("abt", s[3], 1'h1);
        chk("drv", drive_enable, 1'h0);
        rd(OFS_FCODE); chk("fe", s, FC_FOLLOW);
        blocked <= 1'h0; wr(OFS_CMD, CMD_NONE); wr(OFS_CTRL, 32'h0000_0000);
        wt(32'h0000_1F00, 32'h0000_0800);
        rd(OFS_FCODE); chk("hold", s, FC_FOLLOW);
        wr(OFS_CTRL, 32'h0000_0004);
        rd(OFS_STATUS); chk("brk", s[5], 1'h1);
        chk("brel", brake_release, 1'h1);
        wr(OFS_CTRL, 32'h0000_0002);
        wt(32'h0000_1F00, 32'h0000_0100);
        rd(OFS_FCODE); chk("clr", s, FC_NONE);
        hw_fault_code <= FC_TEMP_LO; wr(OFS_CTRL, 32'h0000_0000);
        wt(32'h0000_1F00, 32'h0000_0800);
        rd(OFS_FCODE); chk("hw", s, FC_TEMP_LO);
        rd(8'h24); chk("dec", rr, RESP_DECERR);
        final_report;
    end
endmodule
`default_nettype wire
